// ==== hdl/tmla_defines.vh ====
// Purpose: constants for the temperature monitor limit and alert logic
// Assumes: register map of 8-bit registers, byte addresses
// Notes: limits compare in whatever data format the measurements use
`ifndef TMLA_DEFINES_VH
`define TMLA_DEFINES_VH
`define TMLA_A_LOC_TEMP 8'h00
`define TMLA_A_REM_TEMP_HI 8'h01
`define TMLA_A_STATUS 8'h02
`define TMLA_A_CFG_RD 8'h03
`define TMLA_A_RATE_RD 8'h04
`define TMLA_A_LHI_RD 8'h05
`define TMLA_A_LLO_RD 8'h06
`define TMLA_A_RHI_RD 8'h07
`define TMLA_A_RLO_RD 8'h08
`define TMLA_A_CFG_WR 8'h09
`define TMLA_A_RATE_WR 8'h0A
`define TMLA_A_LHI_WR 8'h0B
`define TMLA_A_LLO_WR 8'h0C
`define TMLA_A_RHI_WR 8'h0D
`define TMLA_A_RLO_WR 8'h0E
`define TMLA_A_ONESHOT 8'h0F
`define TMLA_A_REM_TEMP_LO 8'h10
`define TMLA_A_OFS_HI 8'h11
`define TMLA_A_OFS_LO 8'h12
`define TMLA_A_RHI_LO 8'h13
`define TMLA_A_RLO_LO 8'h14
`define TMLA_A_ROT_LIM 8'h19
`define TMLA_A_LOT_LIM 8'h20
`define TMLA_A_HYST 8'h21
`define TMLA_RST_RATE 8'h08
`define TMLA_RST_CFG 8'h00
`define TMLA_RST_HILIM 8'h55
`define TMLA_RST_LOLIM 8'h00
`define TMLA_RST_OTLIM 8'h55
`define TMLA_RST_HYST 8'h0A
`define TMLA_RST_OFS 8'h00
`define TMLA_RATE_MAX 4'hA
`define TMLA_CFG_MASK 7
`define TMLA_CFG_STBY 6
`define TMLA_CFG_PIN2 5
`define TMLA_CFG_EXT 2
`define TMLA_ST_BUSY 7
`define TMLA_ST_LHI 6
`define TMLA_ST_LLO 5
`define TMLA_ST_RHI 4
`define TMLA_ST_RLO 3
`define TMLA_ST_OPEN 2
`define TMLA_ST_ROT 1
`define TMLA_ST_LOT 0
// period of the fastest rate (64 per second) in ns
`define TMLA_FAST_PERIOD_NS 15625000
`define TMLA_CLK_PERIOD_NS 4
`endif

// ==== hdl/tmla_rate_timer.v ====
// Purpose: conversion start tick generator, period doubled per rate code step
// Assumes: base period is the period of the fastest rate in clock cycles
// Notes: reserved codes behave as the fastest rate; timer restarts on rate change
`include "tmla_defines.vh"
module tmla_rate_timer #(
  parameter BASE_CYCLES = 3906250,
  parameter CW = 34
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire run_i,
  input wire [3:0] rate_code_i,
  output reg tick_o
);
  reg [CW-1:0] cnt;
  reg [3:0] code_q;
  wire [3:0] code_eff;
  wire [CW-1:0] limit;
  assign code_eff = (rate_code_i > `TMLA_RATE_MAX) ? `TMLA_RATE_MAX : rate_code_i;
  // code 0x0A is base, each lower code doubles the interval
  assign limit = ({{(CW-1){1'b0}}, 1'b1} * BASE_CYCLES) << (`TMLA_RATE_MAX - code_eff);
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {CW{1'b0}};
      code_q <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      code_q <= code_eff;
      tick_o <= 1'b0;
      if (!run_i || code_q != code_eff) begin
        cnt <= {CW{1'b0}};
      end else if (cnt >= limit - {{(CW-1){1'b0}}, 1'b1}) begin
        cnt <= {CW{1'b0}};
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== hdl/tmla_core.v ====
// Purpose: rate control, limit compare, flags, alert latch and overtemp outputs
// Assumes: byte register port from a serial slave on the same clock
// Notes: the converter delivers results with a one-cycle done pulse
`include "tmla_defines.vh"
module tmla_core #(
  parameter BASE_CYCLES = (`TMLA_FAST_PERIOD_NS + `TMLA_CLK_PERIOD_NS - 1) / `TMLA_CLK_PERIOD_NS
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire alert_service_i,
  input wire conv_done_i,
  input wire [7:0] local_meas_i,
  input wire [9:0] remote_meas_i,
  input wire remote_open_i,
  output reg [7:0] reg_rdata_o,
  output reg conv_start_o,
  output reg [7:0] local_temp_o,
  output reg [9:0] remote_temp_o,
  output reg ext_range_o,
  output reg alert_n_o,
  output reg overtemp_output_n_o
);
  reg [7:0] rate;
  reg [7:0] cfg;
  reg [7:0] lhi_lim;
  reg [7:0] llo_lim;
  reg [9:0] rhi_lim;
  reg [9:0] rlo_lim;
  reg [7:0] rot_lim;
  reg [7:0] lot_lim;
  reg [7:0] hyst;
  reg [9:0] offset;
  reg busy;
  reg one_shot_pend;
  reg local_high_flag;
  reg local_low_flag;
  reg remote_high_flag;
  reg remote_low_flag;
  reg open_flag;
  reg remote_overtemp_flag;
  reg local_overtemp_flag;
  reg lhi_cond;
  reg llo_cond;
  reg rhi_cond;
  reg rlo_cond;
  reg open_cond;
  reg alert_latch;
  wire tick;
  wire [9:0] rem_corr;
  wire [9:0] rem_hi10;
  wire [9:0] rem_lo10;
  wire n_lhi;
  wire n_llo;
  wire n_rhi;
  wire n_rlo;
  wire n_lot_set;
  wire n_lot_rel;
  wire n_rot_set;
  wire n_rot_rel;
  wire status_rd;
  wire [7:0] status;
  wire second_ot_n;
  wire next_alert_latch;

  // write hit decode, shared by every register
  function wr_hit;
    input w;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = w && (a == target);
    end
  endfunction

  // limit minus hysteresis floored at zero, avoids wrap on low limits
  function [7:0] sub_floor;
    input [7:0] lim;
    input [7:0] h;
    begin
      sub_floor = (lim > h) ? (lim - h) : 8'h00;
    end
  endfunction

  tmla_rate_timer #(
    .BASE_CYCLES(BASE_CYCLES),
    .CW(34)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(!cfg[`TMLA_CFG_STBY]),
    .rate_code_i(rate[3:0]),
    .tick_o(tick)
  );

  // offset added in quarter degrees, wraps as the result register would
  assign rem_corr = remote_meas_i + offset;
  assign rem_hi10 = rhi_lim;
  assign rem_lo10 = rlo_lim;
  assign n_lhi = local_meas_i > lhi_lim;
  assign n_llo = local_meas_i <= llo_lim;
  assign n_rhi = rem_corr > rem_hi10;
  assign n_rlo = rem_corr <= rem_lo10;
  assign n_lot_set = local_meas_i > lot_lim;
  assign n_lot_rel = local_meas_i <= sub_floor(lot_lim, hyst);
  assign n_rot_set = rem_corr[9:2] > rot_lim;
  assign n_rot_rel = rem_corr[9:2] <= sub_floor(rot_lim, hyst);
  assign status_rd = reg_rd_i && (reg_addr_i == `TMLA_A_STATUS);
  assign status = {busy, local_high_flag, local_low_flag, remote_high_flag,
                   remote_low_flag, open_flag, remote_overtemp_flag,
                   local_overtemp_flag};
  assign second_ot_n = !(local_high_flag || remote_high_flag);
  // latch sets from any of the five flags, clears only on service when all clear
  assign next_alert_latch = (local_high_flag || local_low_flag || remote_high_flag ||
                             remote_low_flag || open_flag) ? 1'b1 :
                            (alert_service_i ? 1'b0 : alert_latch);

  // register writes; limits never rewritten on format change
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rate <= `TMLA_RST_RATE;
      cfg <= `TMLA_RST_CFG;
      lhi_lim <= `TMLA_RST_HILIM;
      llo_lim <= `TMLA_RST_LOLIM;
      rhi_lim <= {`TMLA_RST_HILIM, 2'b00};
      rlo_lim <= {`TMLA_RST_LOLIM, 2'b00};
      rot_lim <= `TMLA_RST_OTLIM;
      lot_lim <= `TMLA_RST_OTLIM;
      hyst <= `TMLA_RST_HYST;
      offset <= {`TMLA_RST_OFS, 2'b00};
      ext_range_o <= 1'b0;
    end else begin
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_RATE_WR)) begin
        rate <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_CFG_WR)) begin
        cfg <= reg_wdata_i & 8'hE4;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_LHI_WR)) begin
        lhi_lim <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_LLO_WR)) begin
        llo_lim <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_RHI_WR)) begin
        rhi_lim[9:2] <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_RHI_LO)) begin
        rhi_lim[1:0] <= reg_wdata_i[7:6];
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_RLO_WR)) begin
        rlo_lim[9:2] <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_RLO_LO)) begin
        rlo_lim[1:0] <= reg_wdata_i[7:6];
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_ROT_LIM)) begin
        rot_lim <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_LOT_LIM)) begin
        lot_lim <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_HYST)) begin
        hyst <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_OFS_HI)) begin
        offset[9:2] <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_OFS_LO)) begin
        offset[1:0] <= reg_wdata_i[7:6];
      end
      ext_range_o <= cfg[`TMLA_CFG_EXT];
    end
  end

  // conversion sequencing: periodic tick or one-shot starts both channels
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      one_shot_pend <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (wr_hit(reg_wr_i, reg_addr_i, `TMLA_A_ONESHOT)) begin
        one_shot_pend <= 1'b1;
      end
      if (!busy && (tick || one_shot_pend)) begin
        busy <= 1'b1;
        conv_start_o <= 1'b1;
        one_shot_pend <= 1'b0;
      end else if (busy && conv_done_i) begin
        busy <= 1'b0;
      end
    end
  end

  // conditions sampled at completion; flags: set wins over read clear
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lhi_cond <= 1'b0;
      llo_cond <= 1'b0;
      rhi_cond <= 1'b0;
      rlo_cond <= 1'b0;
      open_cond <= 1'b0;
      local_high_flag <= 1'b0;
      local_low_flag <= 1'b0;
      remote_high_flag <= 1'b0;
      remote_low_flag <= 1'b0;
      open_flag <= 1'b0;
      remote_overtemp_flag <= 1'b0;
      local_overtemp_flag <= 1'b0;
      local_temp_o <= 8'h00;
      remote_temp_o <= 10'h000;
    end else begin
      if (status_rd) begin
        local_high_flag <= lhi_cond;
        local_low_flag <= llo_cond;
        remote_high_flag <= rhi_cond;
        remote_low_flag <= rlo_cond;
        open_flag <= open_cond;
      end
      if (busy && conv_done_i) begin
        local_temp_o <= local_meas_i;
        remote_temp_o <= rem_corr;
        lhi_cond <= n_lhi;
        llo_cond <= n_llo;
        rhi_cond <= n_rhi;
        rlo_cond <= n_rlo;
        open_cond <= remote_open_i;
        if (n_lhi) local_high_flag <= 1'b1;
        if (n_llo) local_low_flag <= 1'b1;
        if (n_rhi) remote_high_flag <= 1'b1;
        if (n_rlo) remote_low_flag <= 1'b1;
        if (remote_open_i) open_flag <= 1'b1;
        if (n_lot_set) begin
          local_overtemp_flag <= 1'b1;
        end else if (n_lot_rel) begin
          local_overtemp_flag <= 1'b0;
        end
        if (n_rot_set) begin
          remote_overtemp_flag <= 1'b1;
        end else if (n_rot_rel) begin
          remote_overtemp_flag <= 1'b0;
        end
      end
    end
  end

  // pin drive; outputs stay live in standby
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alert_latch <= 1'b0;
      alert_n_o <= 1'b1;
      overtemp_output_n_o <= 1'b1;
    end else begin
      alert_latch <= next_alert_latch;
      overtemp_output_n_o <= !(local_overtemp_flag || remote_overtemp_flag);
      if (cfg[`TMLA_CFG_PIN2]) begin
        alert_n_o <= second_ot_n;
      end else begin
        alert_n_o <= !(alert_latch && !cfg[`TMLA_CFG_MASK]);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TMLA_A_LOC_TEMP: reg_rdata_o <= local_temp_o;
        `TMLA_A_REM_TEMP_HI: reg_rdata_o <= remote_temp_o[9:2];
        `TMLA_A_REM_TEMP_LO: reg_rdata_o <= {remote_temp_o[1:0], 6'h00};
        `TMLA_A_STATUS: reg_rdata_o <= status;
        `TMLA_A_CFG_RD: reg_rdata_o <= cfg;
        `TMLA_A_RATE_RD: reg_rdata_o <= rate;
        `TMLA_A_LHI_RD: reg_rdata_o <= lhi_lim;
        `TMLA_A_LLO_RD: reg_rdata_o <= llo_lim;
        `TMLA_A_RHI_RD: reg_rdata_o <= rhi_lim[9:2];
        `TMLA_A_RLO_RD: reg_rdata_o <= rlo_lim[9:2];
        `TMLA_A_RHI_LO: reg_rdata_o <= {rhi_lim[1:0], 6'h00};
        `TMLA_A_RLO_LO: reg_rdata_o <= {rlo_lim[1:0], 6'h00};
        `TMLA_A_OFS_HI: reg_rdata_o <= offset[9:2];
        `TMLA_A_OFS_LO: reg_rdata_o <= {offset[1:0], 6'h00};
        `TMLA_A_ROT_LIM: reg_rdata_o <= rot_lim;
        `TMLA_A_LOT_LIM: reg_rdata_o <= lot_lim;
        `TMLA_A_HYST: reg_rdata_o <= hyst;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// ==== verification/tmla_conv_model.sv ====
// Purpose: converter stand-in for the limit and alert core
// Assumes: a start never arrives while a conversion runs
// Notes: results are valid only in the done cycle
module tmla_conv_model #(
  parameter LAT = 8
) (
  input wire clk_sys_i,
  input wire start_i,
  input wire [7:0] loc_i,
  input wire [9:0] rem_i,
  input wire open_i,
  output reg done_o,
  output wire [7:0] loc_o,
  output wire [9:0] rem_o,
  output wire open_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial done_o = 1'b0;
  // inverted between conversions so stale data never looks valid
  assign loc_o = done_o ? loc_i : ~loc_i;
  assign rem_o = done_o ? rem_i : ~rem_i;
  assign open_o = done_o ? open_i : ~open_i;
  always @(posedge clk_sys_i) begin
    done_o <= (cnt == 1);
    if (start_i) begin
      cnt <= LAT;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== verification/tmla_core_props.sv ====
// Purpose: port properties of the limit and alert core
// Assumes: one clock, register strobes one cycle wide
// Notes: pin changes are traced back to a conversion end, a write or an alert service
module tmla_core_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire alert_service_i,
  input wire conv_done_i,
  input wire [7:0] reg_rdata_o,
  input wire conv_start_o,
  input wire ext_range_o,
  input wire alert_n_o,
  input wire overtemp_output_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg busy_q;
  reg pend_q;
  reg stby_q;
  reg pin2_q;
  reg ext_q;
  reg [7:0] rate_q;
  wire busy_now = conv_start_o | busy_q;
  wire rd_only = reg_rd_i & ~reg_wr_i;
  wire cfg_wr = reg_wr_i & (reg_addr_i == 8'h09);
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      stby_q <= 1'b0;
      pin2_q <= 1'b0;
      ext_q <= 1'b0;
      rate_q <= 8'h08;
    end else begin
      busy_q <= busy_now & ~conv_done_i;
      if (reg_wr_i && reg_addr_i == 8'h0F) begin
        pend_q <= 1'b1;
      end else if (conv_start_o) begin
        pend_q <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == 8'h0A) begin
        rate_q <= reg_wdata_i;
      end
      if (cfg_wr) begin
        stby_q <= reg_wdata_i[6];
        pin2_q <= reg_wdata_i[5];
        ext_q <= reg_wdata_i[2];
      end
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence s_pulse;
    conv_start_o ##1 !conv_start_o;
  endsequence
  sequence s_shot;
    reg_wr_i && reg_addr_i == 8'h0F && stby_q && !busy_now && !pend_q;
  endsequence
  start_pulse_a: assert property (conv_start_o |-> s_pulse)
    else $error("start pulse too wide");
  one_conv_a: assert property (conv_start_o |-> !busy_q)
    else $error("start while busy");
  shot_start_a: assert property (s_shot |-> ##[1:2] s_pulse)
    else $error("one-shot gave no start");
  standby_idle_a: assert property (
    conv_start_o && stby_q && $past(stby_q) && $past(stby_q, 2) |-> pend_q)
    else $error("periodic start in standby");
  busy_bit_a: assert property (
    rd_only && reg_addr_i == 8'h02 && !conv_start_o && !conv_done_i
    |=> reg_rdata_o[7] == $past(busy_q))
    else $error("busy bit wrong");
  rate_read_a: assert property (
    rd_only && reg_addr_i == 8'h04 |=> reg_rdata_o == $past(rate_q))
    else $error("rate readback wrong");
  ot_moment_a: assert property (
    $changed(overtemp_output_n_o)
    |-> $past(conv_done_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("overtemp pin moved without cause");
  alert_hold_a: assert property (
    $rose(alert_n_o) && !pin2_q && !$past(pin2_q)
    |-> $past(alert_service_i) || $past(alert_service_i, 2)
    || $past(alert_service_i, 3) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("alert released without service");
  alert_set_a: assert property (
    $fell(alert_n_o) |-> $past(conv_done_i, 2) || $past(conv_done_i, 3)
    || $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("alert fell without cause");
  ext_follow_a: assert property (cfg_wr |-> ##2 ext_range_o == ext_q)
    else $error("range output wrong");
endmodule
bind tmla_core tmla_core_props tmla_core_props_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .alert_service_i(alert_service_i),
  .conv_done_i(conv_done_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
  .ext_range_o(ext_range_o), .alert_n_o(alert_n_o),
  .overtemp_output_n_o(overtemp_output_n_o)
);

// ==== verification/tb_tmla_core.sv ====
// Purpose: self-checking bench for the limit and alert core
// Assumes: converter stand-in answers each start after a fixed latency
// Notes: base period cut to 16 cycles so every rate code fits in one run
`include "tmla_defines.vh"
module tb_tmla_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 16;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg alert_service_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg [7:0] loc_v = 8'h20;
  reg [9:0] rem_v = 10'h080;
  reg open_v = 1'b0;
  reg [7:0] rd_v, lv, f1, f2;
  reg [9:0] rv, ofs;
  reg [7:0] ot_l [0:4] = '{8'h56, 8'h4C, 8'h4B, 8'h30, 8'h30};
  reg [9:0] ot_r [0:4] = '{10'h080, 10'h080, 10'h080, 10'h158, 10'h12C};
  reg ot_e [0:4] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  integer seed = 32'h96E492F3;
  int num_errors = 0;
  int cmp_count = 0;
  int i, n;
  wire conv_done_i, remote_open_i, conv_start_o, ext_range_o, alert_n_o, overtemp_output_n_o;
  wire [7:0] local_meas_i, reg_rdata_o, local_temp_o;
  wire [9:0] remote_meas_i, remote_temp_o;
  always #2 clk_sys_i = ~clk_sys_i;
  tmla_core #(.BASE_CYCLES(BASE)) tmla_core_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .alert_service_i(alert_service_i),
    .conv_done_i(conv_done_i), .local_meas_i(local_meas_i), .remote_meas_i(remote_meas_i),
    .remote_open_i(remote_open_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
    .local_temp_o(local_temp_o), .remote_temp_o(remote_temp_o), .ext_range_o(ext_range_o),
    .alert_n_o(alert_n_o), .overtemp_output_n_o(overtemp_output_n_o));
  tmla_conv_model tmla_conv_model_i (
    .clk_sys_i(clk_sys_i), .start_i(conv_start_o), .loc_i(loc_v), .rem_i(rem_v),
    .open_i(open_v), .done_o(conv_done_i), .loc_o(local_meas_i), .rem_o(remote_meas_i),
    .open_o(remote_open_i));
  function automatic [7:0] exp_flags(input [7:0] l, input [9:0] r, input o);
    exp_flags = {1'b0, l > 8'h50, l <= 8'h00, r > 10'h154, r <= 10'h000, o, 2'b00};
  endfunction
  task automatic check(input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic bus(input w, input [7:0] a, input [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask
  task automatic service;
    @(posedge clk_sys_i);
    alert_service_i <= 1'b1;
    @(posedge clk_sys_i);
    alert_service_i <= 1'b0;
    idle(4);
  endtask
  task automatic span(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n = n + 1;
    end while (conv_start_o !== 1'b1 && n < lim);
  endtask
  task automatic shot(input [7:0] l, input [9:0] r, input o, input b);
    int k;
    loc_v = l;
    rem_v = r;
    open_v = o;
    bus(1'b1, `TMLA_A_ONESHOT, 8'($random(seed)));
    if (b) begin
      idle(2);
      bus(1'b0, `TMLA_A_STATUS, 8'h00);
      check(rd_v[7], 1'b1);
    end
    k = 0;
    while (conv_done_i !== 1'b1 && k < 60) begin
      @(posedge clk_sys_i);
      #1 k = k + 1;
    end
    if (k == 60) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
    idle(5);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(1'b0, `TMLA_A_RATE_RD, 8'h00);
    check(rd_v, 8'h08);
    bus(1'b0, `TMLA_A_HYST, 8'h00);
    check(rd_v, 8'h0A);
    bus(1'b0, `TMLA_A_OFS_HI, 8'h00);
    check(rd_v, 8'h00);
    $display("reset test done");
    // code 0x0B is reserved and must run at the fastest interval
    for (i = 0; i <= 11; i = i + 1) begin
      bus(1'b1, `TMLA_A_RATE_WR, i[7:0]);
      bus(1'b0, `TMLA_A_RATE_RD, 8'h00);
      check(rd_v, i[7:0]);
      span(BASE << 11);
      span(BASE << 11);
      check(n[15:0], 16'(BASE << (10 - ((i > 10) ? 10 : i))));
      if (n >= (BASE << 11)) print_verdict;
    end
    bus(1'b1, `TMLA_A_CFG_WR, 8'h40);
    idle(4);
    span(100);
    check(n[15:0], 16'h0064);
    $display("rate test done");
    bus(1'b1, `TMLA_A_LHI_WR, 8'h50);
    lv = 8'h51 + 8'($random(seed) & 3);
    rv = 10'h004 + 10'($random(seed) & 255);
    f1 = 8'($random(seed));
    shot(lv, rv, f1[0], 1'b0);
    check(alert_n_o, 1'b0);
    check(local_temp_o, lv);
    f1 = exp_flags(lv, rv, f1[0]);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    check(rd_v, f1);
    shot(8'h50, 10'h000, 1'b0, 1'b0);
    f2 = exp_flags(8'h50, 10'h000, 1'b0);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    check(rd_v, f1 | f2);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    check(rd_v, f2);
    service;
    check(alert_n_o, 1'b0);
    shot(8'h30, 10'h080, 1'b0, 1'b0);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    check(rd_v, f2);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    check(rd_v, 8'h00);
    check(alert_n_o, 1'b0);
    service;
    check(alert_n_o, 1'b1);
    $display("flag test done");
    for (i = 0; i < 5; i = i + 1) begin
      shot(ot_l[i], ot_r[i], 1'b0, 1'b0);
      check(overtemp_output_n_o, ot_e[i]);
      if (i == 3) begin
        bus(1'b0, `TMLA_A_STATUS, 8'h00);
        check(rd_v[1:0], 2'b10);
      end
    end
    $display("overtemp test done");
    bus(1'b1, `TMLA_A_CFG_WR, 8'h60);
    shot(8'h30, 10'h080, 1'b0, 1'b0);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    idle(4);
    check(alert_n_o, 1'b1);
    shot(8'h52, 10'h080, 1'b0, 1'b0);
    check(alert_n_o, 1'b0);
    shot(8'h30, 10'h000, 1'b0, 1'b0);
    bus(1'b0, `TMLA_A_STATUS, 8'h00);
    idle(4);
    check(alert_n_o, 1'b1);
    bus(1'b1, `TMLA_A_CFG_WR, 8'hC0);
    idle(4);
    check(alert_n_o, 1'b1);
    bus(1'b1, `TMLA_A_CFG_WR, 8'h40);
    idle(4);
    check(alert_n_o, 1'b0);
    $display("pin mode test done");
    ofs = 10'($random(seed));
    bus(1'b1, `TMLA_A_OFS_HI, ofs[9:2]);
    bus(1'b1, `TMLA_A_OFS_LO, {ofs[1:0], 6'h00});
    bus(1'b0, `TMLA_A_OFS_LO, 8'h00);
    check(rd_v[7:6], ofs[1:0]);
    rv = 10'($random(seed));
    shot(8'h30, rv, 1'b0, 1'b0);
    rv = rv + ofs;
    check(remote_temp_o, rv);
    bus(1'b1, `TMLA_A_CFG_WR, 8'h44);
    idle(3);
    check(ext_range_o, 1'b1);
    bus(1'b0, `TMLA_A_LHI_RD, 8'h00);
    check(rd_v, 8'h50);
    bus(1'b1, `TMLA_A_RHI_LO, 8'hC0);
    bus(1'b0, `TMLA_A_RHI_LO, 8'h00);
    check(rd_v, 8'hC0);
    bus(1'b0, `TMLA_A_ONESHOT, 8'h00);
    check(rd_v, 8'h00);
    shot(8'h30, 10'h080, 1'b0, 1'b1);
    $display("offset and range test done");
    print_verdict;
  end
endmodule
